// ---- encoder_input_conditioning_consts.vh ----
`ifndef ENCODER_INPUT_CONDITIONING_CONSTS_VH
`define ENCODER_INPUT_CONDITIONING_CONSTS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define ENC_ADDR_W              4
`define ENC_IO_CONTROL_ADDR     4'h0
`define ENC_IO_CONTROL_HI_ADDR  4'h4

// ----------------------------------------------------------------------------
// encoder_io_control field positions
// ----------------------------------------------------------------------------
`define ENC_BIT_CHAN_A_STATE    0
`define ENC_BIT_CHAN_B_STATE    1
`define ENC_BIT_INDEX_STATE     2
`define ENC_BIT_HOME_STATE      3
`define ENC_BIT_CHAN_A_INVERT   4
`define ENC_BIT_CHAN_B_INVERT   5
`define ENC_BIT_INDEX_INVERT    6
`define ENC_BIT_HOME_INVERT     7
`define ENC_BIT_AB_SWAP         8
`define ENC_OUT_FUNC_LSB        9
`define ENC_OUT_FUNC_MSB        10
`define ENC_FILT_DIV_LSB        11
`define ENC_FILT_DIV_MSB        13
`define ENC_BIT_FILTER_EN       14
`define ENC_BIT_POS_CAPTURE_EN  15
`define ENC_BIT_HOME_CAPTURE_EN 0

// ----------------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------------
`define ENC_CTRL_RESET          12'h000
`define ENC_HI_RESET            1'h0
`define ENC_RESP_OKAY           2'h0
`define ENC_RESP_SLVERR         2'h2

`endif

// ---- encoder_input_conditioning.v ----
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "encoder_input_conditioning_consts.vh"

// Summary of operation
// - The index status bit reads the index pin exclusive-ORed with the index invert setting.
// - Without swap, the channel B status bit is the B pin, inverted when channel B invert is set.
// - With swap, the channel B status bit comes from the A pin, inverted when channel B invert is set.
// - Without swap, the channel A status bit is the A pin, inverted when channel A invert is set.
// - With swap, the channel A status bit comes from the B pin, inverted when channel A invert is set.
// - Channel A and B status bits are read-only and show the signals after inversion and swap.
module encoder_input_conditioning
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [31:0] awaddr,
    input  wire [2:0]  awprot,
    input  wire        awvalid,
    output reg         awready,
    // AXI4-Lite write data
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // AXI4-Lite write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // AXI4-Lite read address
    input  wire [31:0] araddr,
    input  wire [2:0]  arprot,
    input  wire        arvalid,
    output reg         arready,
    // AXI4-Lite read data
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // Encoder pins
    input  wire        chan_a_pin,
    input  wire        chan_b_pin,
    input  wire        index_pulse_pin,
    input  wire        home_pin,
    // Conditioned signals to decoder, counter and capture logic
    output reg         cond_chan_a,
    output reg         cond_chan_b,
    output reg         cond_index,
    output reg         cond_home,
    // Stored settings for downstream logic
    output reg         pos_capture_en,
    output reg         filter_en,
    output reg  [2:0]  filter_div,
    output reg  [1:0]  out_func,
    output reg         home_capture_en
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function cond_bit;
        input pin;
        input invert;
        begin
            cond_bit = pin ^ invert;
        end
    endfunction

    function is_ctrl_lo;
        input [`ENC_ADDR_W-1:0] addr;
        begin
            is_ctrl_lo = (addr == `ENC_IO_CONTROL_ADDR);
        end
    endfunction

    function is_ctrl_hi;
        input [`ENC_ADDR_W-1:0] addr;
        begin
            is_ctrl_hi = (addr == `ENC_IO_CONTROL_HI_ADDR);
        end
    endfunction

    function is_mapped;
        input [`ENC_ADDR_W-1:0] addr;
        begin
            is_mapped = is_ctrl_lo(addr) || is_ctrl_hi(addr);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    reg                    chan_a_invert;
    reg                    chan_b_invert;
    reg                    index_invert;
    reg                    home_invert;
    reg                    ab_swap;
    reg                    aw_held;
    reg                    w_held;
    // Write request parked until both halves are in
    reg [`ENC_ADDR_W-1:0]  wr_addr;
    // Only the low half-word carries fields
    reg [15:0]             wr_data;
    reg [1:0]              wr_strb;
    wire                   do_write;
    reg [15:0]             encoder_io_control;
    reg [15:0]             encoder_io_control_hi;
    reg [31:0]             read_word;
    reg [1:0]              read_resp;
    wire                   swapped_a;
    wire                   swapped_b;

    // ------------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------------
    // Swap ahead of inversion; each invert follows its output channel
    assign swapped_a = ab_swap ? chan_b_pin : chan_a_pin;
    assign swapped_b = ab_swap ? chan_a_pin : chan_b_pin;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cond_chan_a <= 1'b0;
            cond_chan_b <= 1'b0;
            cond_index  <= 1'b0;
            cond_home   <= 1'b0;
        end
        else
        begin
            cond_chan_a <= cond_bit(swapped_a, chan_a_invert);
            cond_chan_b <= cond_bit(swapped_b, chan_b_invert);
            cond_index  <= cond_bit(index_pulse_pin, index_invert);
            cond_home   <= cond_bit(home_pin, home_invert);
        end
    end

    // ------------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------------
    // Status bits come from the conditioning flops; writes never reach them
    always @*
    begin
        encoder_io_control                                      = 16'h0000;
        encoder_io_control[`ENC_BIT_CHAN_A_STATE]               = cond_chan_a;
        encoder_io_control[`ENC_BIT_CHAN_B_STATE]               = cond_chan_b;
        encoder_io_control[`ENC_BIT_INDEX_STATE]                = cond_index;
        encoder_io_control[`ENC_BIT_HOME_STATE]                 = cond_home;
        encoder_io_control[`ENC_BIT_CHAN_A_INVERT]              = chan_a_invert;
        encoder_io_control[`ENC_BIT_CHAN_B_INVERT]              = chan_b_invert;
        encoder_io_control[`ENC_BIT_INDEX_INVERT]               = index_invert;
        encoder_io_control[`ENC_BIT_HOME_INVERT]                = home_invert;
        encoder_io_control[`ENC_BIT_AB_SWAP]                    = ab_swap;
        encoder_io_control[`ENC_OUT_FUNC_MSB:`ENC_OUT_FUNC_LSB] = out_func;
        encoder_io_control[`ENC_FILT_DIV_MSB:`ENC_FILT_DIV_LSB] = filter_div;
        encoder_io_control[`ENC_BIT_FILTER_EN]                  = filter_en;
        encoder_io_control[`ENC_BIT_POS_CAPTURE_EN]             = pos_capture_en;
    end

    // Only the capture enable is implemented in the high word
    always @*
    begin
        encoder_io_control_hi                                   = 16'h0000;
        encoder_io_control_hi[`ENC_BIT_HOME_CAPTURE_EN]         = home_capture_en;
    end

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // One write at a time; the response must be taken before the next
    assign do_write = aw_held && w_held && !bvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= {`ENC_ADDR_W{1'b0}};
            wr_data <= 16'h0000;
            wr_strb <= 2'h0;
            bvalid  <= 1'b0;
            bresp   <= `ENC_RESP_OKAY;
        end
        else
        begin
            // Address and data may arrive in either order
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                wr_addr <= awaddr[`ENC_ADDR_W-1:0];
            end
            if (wvalid && wready)
            begin
                w_held  <= 1'b1;
                wready  <= 1'b0;
                wr_data <= wdata[15:0];
                wr_strb <= wstrb[1:0];
            end
            if (do_write)
            begin
                bvalid  <= 1'b1;
                bresp   <= is_mapped(wr_addr) ? `ENC_RESP_OKAY : `ENC_RESP_SLVERR;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Writable fields only; status bits ignore writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {pos_capture_en, filter_en, filter_div, out_func, ab_swap,
             home_invert, index_invert, chan_b_invert, chan_a_invert} <= `ENC_CTRL_RESET;
            home_capture_en <= `ENC_HI_RESET;
        end
        else if (do_write)
        begin
            if (is_ctrl_lo(wr_addr))
            begin
                if (wr_strb[0])
                begin
                    chan_a_invert <= wr_data[`ENC_BIT_CHAN_A_INVERT];
                    chan_b_invert <= wr_data[`ENC_BIT_CHAN_B_INVERT];
                    index_invert  <= wr_data[`ENC_BIT_INDEX_INVERT];
                    home_invert   <= wr_data[`ENC_BIT_HOME_INVERT];
                end
                if (wr_strb[1])
                begin
                    ab_swap        <= wr_data[`ENC_BIT_AB_SWAP];
                    out_func       <= wr_data[`ENC_OUT_FUNC_MSB:`ENC_OUT_FUNC_LSB];
                    filter_div     <= wr_data[`ENC_FILT_DIV_MSB:`ENC_FILT_DIV_LSB];
                    filter_en      <= wr_data[`ENC_BIT_FILTER_EN];
                    pos_capture_en <= wr_data[`ENC_BIT_POS_CAPTURE_EN];
                end
            end
            else if (is_ctrl_hi(wr_addr) && wr_strb[0])
            begin
                home_capture_en <= wr_data[`ENC_BIT_HOME_CAPTURE_EN];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read word selection
    // ------------------------------------------------------------------------
    // Status bits are those held in the flops at the take edge
    always @*
    begin
        read_word = 32'h00000000;
        read_resp = `ENC_RESP_SLVERR;
        if (is_ctrl_lo(araddr[`ENC_ADDR_W-1:0]))
        begin
            read_word = {16'h0000, encoder_io_control};
            read_resp = `ENC_RESP_OKAY;
        end
        else if (is_ctrl_hi(araddr[`ENC_ADDR_W-1:0]))
        begin
            read_word = {16'h0000, encoder_io_control_hi};
            read_resp = `ENC_RESP_OKAY;
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `ENC_RESP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= read_word;
                rresp   <= read_resp;
            end
            if (rvalid && rready)
            begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule

// ---- enc_cond_chk.sv ----
`timescale 1ns/1ps
module enc_cond_chk (
    // Clock and reset
    input wire        aclk, aresetn,
    // Bus handshakes
    input wire        awready, wready, bvalid, bready, arready, rvalid, rready,
    input wire [31:0] araddr, rdata,
    input wire [1:0]  rresp,
    // Pins and conditioned levels
    input wire        chan_a_pin, chan_b_pin, index_pulse_pin, home_pin,
    input wire        cond_chan_a, cond_chan_b, cond_index, cond_home
);
    // -------------------------------------------------------------------
    // Settle time after reset
    // -------------------------------------------------------------------
    reg [2:0] up;
    always @(posedge aclk)
        up <= aresetn ? {up[1:0], 1'h1} : 3'h0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_INDEX_FOLLOWS:
        assert property (up[2] && !$rose(bvalid) && $changed(index_pulse_pin) |=> $changed(cond_index))
        else $error("index status missed a pin change");
    AST_AB_FOLLOWS:
        assert property (up[2] && !$rose(bvalid) && $changed(chan_a_pin) && $stable(chan_b_pin)
            |=> $changed(cond_chan_a) != $changed(cond_chan_b)) else $error("one pin moved, not one status");
    AST_HOME_FOLLOWS:
        assert property (up[2] && !$rose(bvalid) && $changed(home_pin) |=> $changed(cond_home))
        else $error("home status missed a pin change");
    AST_STATUS_SNAP:
        assert property ($fell(arready) && $past(araddr[3:0]) == 4'h0 |-> rresp == 2'h0
            && rdata[0] == $past(cond_chan_a) && rdata[1] == $past(cond_chan_b)
            && rdata[2] == $past(cond_index) && rdata[3] == $past(cond_home))
        else $error("status read differs from conditioned levels");
    AST_READ_ANSWER:
        assert property ($fell(arready) |-> rvalid) else $error("read not answered");
    AST_READ_DONE:
        assert property (rvalid && rready |=> !rvalid && arready) else $error("read not closed");
    AST_WRITE_ANSWER:
        assert property ($fell(awready) && $fell(wready) |=> bvalid) else $error("write not answered");
    AST_WRITE_DONE:
        assert property (bvalid && bready |=> !bvalid && awready && wready) else $error("write not closed");
    AST_HIGH_ZERO:
        assert property (rvalid |-> rdata[31:16] == 16'h0) else $error("upper read bits not zero");
endmodule
bind encoder_input_conditioning enc_cond_chk chk (.aclk(aclk), .aresetn(aresetn), .awready(awready),
    .wready(wready), .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid), .rready(rready),
    .araddr(araddr), .rdata(rdata), .rresp(rresp), .chan_a_pin(chan_a_pin), .chan_b_pin(chan_b_pin),
    .index_pulse_pin(index_pulse_pin), .home_pin(home_pin), .cond_chan_a(cond_chan_a),
    .cond_chan_b(cond_chan_b), .cond_index(cond_index), .cond_home(cond_home));

// ---- enc_model.sv ----
`timescale 1ns/1ps
module enc_model (
    // Motion from the bench
    input  wire aclk,
    input  wire step,
    input  wire dir,
    input  wire home_level,
    // Encoder outputs
    output wire qa,
    output wire qb,
    output wire idx,
    output wire home
);
    reg [3:0] pos = 4'h0;
    // Gray order: one channel moves per step
    assign qa   = pos[1];
    assign qb   = pos[1] ^ pos[0];
    assign idx  = pos == 4'h0;
    assign home = home_level;
    always @(posedge aclk)
        if (step)
            pos <= dir ? pos + 4'h1 : pos - 4'h1;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, step, dir, home_level;
    reg  [31:0] awaddr, wdata, araddr, seed, rd;
    reg  [15:0] ctrl, msk;
    reg  [3:0]  wstrb;
    reg  [1:0]  rsp;
    wire        awready, wready, bvalid, arready, rvalid, qa, qb, idx, home, pos_capture_en, filter_en;
    wire        cond_chan_a, cond_chan_b, cond_index, cond_home, home_capture_en;
    wire [31:0] rdata;
    wire [2:0]  filter_div;
    wire [1:0]  bresp, rresp, out_func;
    int         mismatches, check_count, cyc, i;
    encoder_input_conditioning encoder_input_conditioning_inst (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .chan_a_pin(qa), .chan_b_pin(qb), .index_pulse_pin(idx), .home_pin(home),
        .cond_chan_a(cond_chan_a), .cond_chan_b(cond_chan_b), .cond_index(cond_index), .cond_home(cond_home),
        .pos_capture_en(pos_capture_en), .filter_en(filter_en), .filter_div(filter_div), .out_func(out_func),
        .home_capture_en(home_capture_en));
    enc_model enc_model_inst (.aclk(aclk), .step(step), .dir(dir), .home_level(home_level), .qa(qa), .qb(qb),
        .idx(idx), .home(home));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [3:0] status(input [15:0] c);
        status = {home ^ c[7], idx ^ c[6], (c[8] ? qa : qb) ^ c[5], (c[8] ? qb : qa) ^ c[4]};
    endfunction
    task wr(input [31:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            do
            begin
                @(posedge aclk);
                if (awready) awvalid <= 1'h0;
                if (wready) wvalid <= 1'h0;
            end while (!bvalid);
            bready <= 1'h0;
            rsp = bresp;
        end
    endtask
    task rdr(input [31:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            do
            begin
                @(posedge aclk);
                if (arready) arvalid <= 1'h0;
            end while (!rvalid);
            rready <= 1'h0;
            rd = rdata;
            rsp = rresp;
        end
    endtask
    task final_report;
        begin
            $display("Checks %0d, mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial
    begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            final_report;
        end
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, step, dir, home_level} = 9'h0;
        {awaddr, wdata, araddr, wstrb, ctrl} = 116'h0;
        seed = 32'h2137BC07;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(32'h0);
        `CHK({rsp, rd}, {18'h0, ctrl[15:4], status(ctrl)})
        $display("Test reset done");
        // ---------------------------------------------------------------
        // Random settings, strobes and motion
        // ---------------------------------------------------------------
        for (i = 0; i < 60; i++)
        begin
            seed = lfsr(seed);
            msk = {{8{seed[29]}}, {8{seed[28]}}} & 16'hFFF0;
            wr(32'h0, seed, seed[31:28]);
            ctrl = (ctrl & ~msk) | (seed[15:0] & msk);
            `CHK(rsp, 2'h0)
            dir <= seed[19];
            home_level <= seed[20];
            step <= 1'h1;
            repeat (seed[18:16] + 1) @(posedge aclk);
            step <= 1'h0;
            rdr(32'h0);
            `CHK(rd, {16'h0, ctrl[15:4], status(ctrl)})
            `CHK({cond_home, cond_index, cond_chan_b, cond_chan_a}, status(ctrl))
            `CHK({pos_capture_en, filter_en, filter_div, out_func}, ctrl[15:9])
        end
        $display("Test random done");
        wr(32'h4, 32'hFFFFFFFF, 4'hF);
        rdr(32'h4);
        `CHK({rd, home_capture_en}, 33'h3)
        wr(32'h8, 32'h0, 4'hF);
        `CHK(rsp, 2'h2)
        rdr(32'hC);
        `CHK({rsp, rd}, 34'h200000000)
        $display("Test map done");
        final_report;
    end
endmodule
